// ### src/pcio_pkg.sv
// Package with constants and carrier types for the I/O port decode block.
`default_nettype none
package pcio_pkg;
   localparam int          IO_ADDR_W      = 10;
   localparam logic [9:0]  BASE_RESET     = 10'h0300;
   localparam logic [9:0]  BASE_MAX       = 10'h03FC;
   localparam logic [1:0]  OFS_TIMER_DATA = 2'h0;
   localparam logic [1:0]  OFS_TIMER_CMD  = 2'h1;
   localparam logic [1:0]  OFS_DIG_IN     = 2'h2;
   localparam logic [1:0]  OFS_DIG_OUT    = 2'h3;
   localparam logic [7:0]  DOUT_RESET     = 8'h00;
   localparam logic [7:0]  DIN_RESET      = 8'h00;
   localparam logic [2:0]  IRQ_LVL_NONE   = 3'h0;
   localparam logic [2:0]  IRQ_LVL_MIN    = 3'h2;
   localparam logic [2:0]  IRQ_LVL_MAX    = 3'h7;
   localparam int          IRQ_LINES      = 6;

   typedef struct packed {
      logic [9:0] addr;
      logic [7:0] wdata;
      logic       rd;
      logic       wr;
   } pcio_req_t;

   typedef struct packed {
      logic [7:0] data;
      logic       cs_data;
      logic       cs_cmd;
      logic       rd;
      logic       wr;
   } pcio_tmr_t;
endpackage : pcio_pkg
`default_nettype wire

// ### src/pcio_irq_route.sv
// Interrupt edge detection and routing onto one selected host level.
`default_nettype none
module pcio_irq_route
   import pcio_pkg::*;
#(
   parameter int LINES = 6
) (
   input  wire logic             mclk,
   input  wire logic             rst_n,
   input  wire logic             clk_en,
   input  wire logic             irq_in,
   input  wire logic             irq_enable_n,
   input  wire logic [2:0]       irq_level,
   output logic      [LINES-1:0] irq_out,
   output logic      [LINES-1:0] irq_oe
);
   import pcio_pkg::*;

   logic irq_in_d_r;
   logic irq_req_r;
   logic rise;
   logic en;

   assign rise = irq_in & ~irq_in_d_r;
   assign en   = ~irq_enable_n;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irq_in_d_r <= 1'b0;
         irq_req_r  <= 1'b0;
      end else if (clk_en) begin
         irq_in_d_r <= irq_in;
         // A rising edge raises the request; it falls again with the input.
         if (!en)
            irq_req_r <= 1'b0;
         else if (rise)
            irq_req_r <= 1'b1;
         else if (!irq_in)
            irq_req_r <= 1'b0;
      end
   end

   // Each level is driven only when enabled and selected; setting 0 drives none.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irq_out <= '0;
         irq_oe  <= '0;
      end else if (clk_en) begin
         for (int i = 0; i < LINES; i++) begin
            irq_oe[i]  <= en && (irq_level == 3'(i + 2));
            irq_out[i] <= en && (irq_level == 3'(i + 2)) && irq_req_r;
         end
      end
   end
endmodule : pcio_irq_route
`default_nettype wire

// ### src/pcio_port.sv
// Top of the host I/O decode: four byte ports, digital I/O latches and interrupt routing.
`default_nettype none
module pcio_port
   import pcio_pkg::*;
#(
   parameter int          LINES      = IRQ_LINES,
   parameter logic [7:0]  BASE_SWITCH = BASE_RESET[9:2]
) (
   input  wire logic                  mclk,
   input  wire logic                  rst_n,
   input  wire logic                  clk_en,
   input  wire pcio_pkg::pcio_req_t   host_req,
   input  wire logic [7:0]            base_switch,
   input  wire logic                  base_switch_use,
   output logic      [7:0]            host_rdata,
   output logic                       host_rvalid,
   output pcio_pkg::pcio_tmr_t        timer_bus,
   input  wire logic [7:0]            timer_rdata,
   input  wire logic [7:0]            digital_input_bits,
   input  wire logic                  input_strobe,
   output logic      [7:0]            digital_output_bits,
   input  wire logic                  irq_in,
   input  wire logic                  irq_enable_n,
   input  wire logic [2:0]            irq_level,
   output logic      [LINES-1:0]      irq_out,
   output logic      [LINES-1:0]      irq_oe
);
   import pcio_pkg::*;

   logic [7:0] base_r;
   logic       base_loaded_r;
   logic [7:0] din_r;
   logic       strobe_d_r;
   logic       hit;
   logic       sel_data;
   logic       sel_cmd;
   logic       sel_din;
   logic       sel_dout;
   logic [7:0] rd_mux;

   // Upper bits match the switch, low bits pick the port; anything else is ignored.
   assign hit      = (host_req.addr[9:2] == base_r) && (host_req.rd ^ host_req.wr);
   assign sel_data = hit && (host_req.addr[1:0] == OFS_TIMER_DATA);
   assign sel_cmd  = hit && (host_req.addr[1:0] == OFS_TIMER_CMD);
   assign sel_din  = hit && (host_req.addr[1:0] == OFS_DIG_IN);
   assign sel_dout = hit && (host_req.addr[1:0] == OFS_DIG_OUT);

   // Only byte lanes exist, so each readable port answers with eight bits; the output port is not read back.
   assign rd_mux = (sel_data || sel_cmd) ? timer_rdata :
                   sel_din               ? din_r       : 8'h00;

   // The switch is sampled once after reset; aligned by construction.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         base_r        <= BASE_RESET[9:2];
         base_loaded_r <= 1'b0;
      end else if (clk_en && !base_loaded_r) begin
         base_r        <= base_switch_use ? base_switch : BASE_SWITCH;
         base_loaded_r <= 1'b1;
      end
   end

   // Inputs are captured on a rising strobe so the host reads a stable byte.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         din_r      <= DIN_RESET;
         strobe_d_r <= 1'b0;
      end else if (clk_en) begin
         strobe_d_r <= input_strobe;
         if (input_strobe && !strobe_d_r)
            din_r <= digital_input_bits;
      end
   end

   // Output latch holds its byte until the next write.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         digital_output_bits <= DOUT_RESET;
      else if (clk_en && sel_dout && host_req.wr)
         digital_output_bits <= host_req.wdata;
   end

   // Timer strobes are registered pulses; a lingering host strobe holds them high for as long as it lasts.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         timer_bus   <= '0;
         host_rdata  <= 8'h00;
         host_rvalid <= 1'b0;
      end else if (clk_en) begin
         timer_bus.data    <= host_req.wdata;
         timer_bus.cs_data <= sel_data;
         timer_bus.cs_cmd  <= sel_cmd;
         timer_bus.rd      <= (sel_data || sel_cmd) && host_req.rd;
         timer_bus.wr      <= (sel_data || sel_cmd) && host_req.wr;
         host_rdata        <= rd_mux;
         host_rvalid       <= hit && host_req.rd && !sel_dout;
      end
   end

   pcio_irq_route #(
      .LINES (LINES)
   ) u_irq (
      .mclk         (mclk),
      .rst_n        (rst_n),
      .clk_en       (clk_en),
      .irq_in       (irq_in),
      .irq_enable_n (irq_enable_n),
      .irq_level    (irq_level),
      .irq_out      (irq_out),
      .irq_oe       (irq_oe)
   );

   property p_out_hold;
      @(posedge mclk) disable iff (!rst_n)
      !(clk_en && sel_dout && host_req.wr) |=> $stable(digital_output_bits);
   endproperty
   a_out_hold: assert property (p_out_hold) else $error("Output latch changed.");

   property p_out_write;
      @(posedge mclk) disable iff (!rst_n)
      (clk_en && sel_dout && host_req.wr) |=> digital_output_bits == $past(host_req.wdata);
   endproperty
   a_out_write: assert property (p_out_write) else $error("Output write lost.");

   property p_miss;
      @(posedge mclk) disable iff (!rst_n)
      (clk_en && host_req.addr[9:2] != base_r) |=> !host_rvalid && !timer_bus.cs_data
         && !timer_bus.cs_cmd;
   endproperty
   a_miss: assert property (p_miss) else $error("Foreign address answered.");

   property p_din_read;
      @(posedge mclk) disable iff (!rst_n)
      (clk_en && sel_din && host_req.rd) |=> host_rvalid && host_rdata == $past(din_r);
   endproperty
   a_din_read: assert property (p_din_read) else $error("Input read wrong.");

   property p_cmd_sel;
      @(posedge mclk) disable iff (!rst_n)
      (clk_en && sel_cmd && host_req.wr) |=> timer_bus.cs_cmd && timer_bus.wr
         && !timer_bus.cs_data;
   endproperty
   a_cmd_sel: assert property (p_cmd_sel) else $error("Command write misrouted.");

   property p_rd_only;
      @(posedge mclk) disable iff (!rst_n)
      (clk_en && !host_req.rd) |=> !host_rvalid;
   endproperty
   a_rd_only: assert property (p_rd_only) else $error("Valid without read.");

   property p_out_rd;
      @(posedge mclk) disable iff (!rst_n)
      (clk_en && sel_dout && host_req.rd) |=> !host_rvalid && !timer_bus.rd;
   endproperty
   a_out_rd: assert property (p_out_rd) else $error("Output read answered.");

   property p_din_wr;
      @(posedge mclk) disable iff (!rst_n)
      (clk_en && sel_din && host_req.wr) |=> !timer_bus.cs_data && !timer_bus.cs_cmd
         && !host_rvalid;
   endproperty
   a_din_wr: assert property (p_din_wr) else $error("Input write accepted.");

   property p_data_rd;
      @(posedge mclk) disable iff (!rst_n)
      (clk_en && sel_data && host_req.rd) |=> timer_bus.cs_data && timer_bus.rd && host_rvalid
         && host_rdata == $past(timer_rdata);
   endproperty
   a_data_rd: assert property (p_data_rd) else $error("Data read misrouted.");

   property p_data_wr;
      @(posedge mclk) disable iff (!rst_n)
      (clk_en && sel_data && host_req.wr) |=> timer_bus.cs_data && timer_bus.wr
         && !timer_bus.cs_cmd && timer_bus.data == $past(host_req.wdata);
   endproperty
   a_data_wr: assert property (p_data_wr) else $error("Data write misrouted.");

   property p_stat_rd;
      @(posedge mclk) disable iff (!rst_n)
      (clk_en && sel_cmd && host_req.rd) |=> timer_bus.cs_cmd && timer_bus.rd && host_rvalid
         && host_rdata == $past(timer_rdata);
   endproperty
   a_stat_rd: assert property (p_stat_rd) else $error("Status read misrouted.");

   property p_din_take;
      @(posedge mclk) disable iff (!rst_n)
      (clk_en && input_strobe && !strobe_d_r) |=> din_r == $past(digital_input_bits);
   endproperty
   a_din_take: assert property (p_din_take) else $error("Input not captured.");

   property p_din_keep;
      @(posedge mclk) disable iff (!rst_n)
      (clk_en && !(input_strobe && !strobe_d_r)) |=> $stable(din_r);
   endproperty
   a_din_keep: assert property (p_din_keep) else $error("Input latch moved.");

   property p_base_keep;
      @(posedge mclk) disable iff (!rst_n)
      base_loaded_r |=> $stable(base_r);
   endproperty
   a_base_keep: assert property (p_base_keep) else $error("Base moved after load.");

   property p_irq_float;
      @(posedge mclk) disable iff (!rst_n)
      (clk_en && irq_enable_n) |=> irq_oe == '0;
   endproperty
   a_irq_float: assert property (p_irq_float) else $error("Driver on while disabled.");

   property p_irq_none;
      @(posedge mclk) disable iff (!rst_n)
      (clk_en && irq_level == IRQ_LVL_NONE) |=> irq_oe == '0;
   endproperty
   a_irq_none: assert property (p_irq_none) else $error("Inactive level drives.");

   property p_irq_edge;
      @(posedge mclk) disable iff (!rst_n)
      (clk_en && !irq_enable_n && irq_in && !$past(irq_in) && irq_level >= IRQ_LVL_MIN)
         ##1 (clk_en && !irq_enable_n && $stable(irq_level)) |=> irq_out != '0;
   endproperty
   a_irq_edge: assert property (p_irq_edge) else $error("Edge gave no request.");
endmodule : pcio_port
`default_nettype wire

// ### test/pcio_host_model.sv
// Host model issuing single byte I/O cycles on the port request bus.
`default_nettype none
module pcio_host_model (
   input  wire logic          mclk,
   output pcio_pkg::pcio_req_t req
);
   timeunit 1ns;
   timeprecision 1ps;
   import pcio_pkg::*;
   initial req = '0;
   // One byte per access, then an idle cycle so back-to-back cycles get recovery time.
   task automatic io(input logic [9:0] a, input logic [7:0] d, input logic w);
      @(posedge mclk);
      req <= '{addr: a, wdata: d, rd: !w, wr: w};
      @(posedge mclk);
      req <= '0;
      #1;
   endtask : io
endmodule : pcio_host_model
`default_nettype wire

// ### test/pcio_port_tb_top.sv
// Self-checking bench for the host I/O port decode block.
`default_nettype none
module pcio_port_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import pcio_pkg::*;
   logic mclk = 0, rst_n = 0, clk_en = 1, base_switch_use = 0, input_strobe = 0;
   logic irq_in = 0, irq_enable_n = 1, host_rvalid;
   logic [7:0] base_switch = 0, timer_rdata = 0, digital_input_bits = 0;
   logic [7:0] host_rdata, digital_output_bits;
   logic [2:0] irq_level = 0;
   logic [5:0] irq_out, irq_oe;
   pcio_req_t host_req;
   pcio_tmr_t timer_bus;
   logic [7:0] tmr_bits;
   assign tmr_bits = {4'h0, timer_bus.cs_data, timer_bus.cs_cmd, timer_bus.rd, timer_bus.wr};
   int failures = 0, compares = 0, cyc = 0;
   always #20 mclk = ~mclk;
   pcio_host_model H (.mclk(mclk), .req(host_req));
   pcio_port DUT (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .host_req(host_req),
      .base_switch(base_switch), .base_switch_use(base_switch_use),
      .host_rdata(host_rdata), .host_rvalid(host_rvalid), .timer_bus(timer_bus),
      .timer_rdata(timer_rdata), .digital_input_bits(digital_input_bits),
      .input_strobe(input_strobe), .digital_output_bits(digital_output_bits),
      .irq_in(irq_in), .irq_enable_n(irq_enable_n), .irq_level(irq_level),
      .irq_out(irq_out), .irq_oe(irq_oe));
   task automatic test_done();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : test_done
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         failures++;
         test_done();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic rd(input logic [9:0] a, input logic v, input logic [7:0] d);
      H.io(a, 8'h00, 1'b0);
      chk({7'h00, host_rvalid}, {7'h00, v});
      if (v) chk(host_rdata, d);
   endtask : rd
   task automatic do_reset();
      @(posedge mclk) rst_n <= 1'b0;
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (2) @(posedge mclk);
   endtask : do_reset
   task automatic t_dout();
      H.io(10'h303, 8'hA5, 1'b1);
      chk(digital_output_bits, 8'hA5);
      H.io(10'h303, 8'h5A, 1'b1);
      H.io(10'h302, 8'hFF, 1'b1);
      H.io(10'h304, 8'h00, 1'b1);
      H.io(10'h2FF, 8'h00, 1'b1);
      chk(digital_output_bits, 8'h5A);
      rd(10'h303, 1'b0, 8'h00);
      rd(10'h304, 1'b0, 8'h00);
   endtask : t_dout
   task automatic t_timer();
      @(posedge mclk) timer_rdata <= 8'h3C;
      rd(10'h300, 1'b1, 8'h3C);
      chk(tmr_bits, 8'h0A);
      H.io(10'h300, 8'h42, 1'b1);
      chk(tmr_bits, 8'h09);
      chk(timer_bus.data, 8'h42);
      H.io(10'h301, 8'hC7, 1'b1);
      chk(tmr_bits, 8'h05);
      chk(timer_bus.data, 8'hC7);
      @(posedge mclk) timer_rdata <= 8'h81;
      #1;
      chk(tmr_bits, 8'h00);
      rd(10'h301, 1'b1, 8'h81);
   endtask : t_timer
   task automatic t_din();
      @(posedge mclk) digital_input_bits <= 8'h96;
      @(posedge mclk) input_strobe <= 1'b1;
      repeat (2) @(posedge mclk);
      digital_input_bits <= 8'h00;
      input_strobe <= 1'b0;
      rd(10'h302, 1'b1, 8'h96);
   endtask : t_din
   task automatic t_irq();
      @(posedge mclk) irq_enable_n <= 1'b0;
      for (int l = 0; l <= 7; l++) begin
         // Settings 0 and 1 select no level, so they must leave every line undriven.
         @(posedge mclk) irq_level <= 3'(l);
         @(posedge mclk) irq_in <= 1'b1;
         repeat (3) @(posedge mclk);
         irq_in <= 1'b0;
         #1;
         chk({2'b00, irq_out}, l < 2 ? 8'h00 : 8'h01 << (l - 2));
         chk({2'b00, irq_oe}, l < 2 ? 8'h00 : 8'h01 << (l - 2));
         repeat (2) @(posedge mclk);
      end
      irq_enable_n <= 1'b1;
      repeat (2) @(posedge mclk);
      irq_in <= 1'b1;
      repeat (3) @(posedge mclk);
      irq_in <= 1'b0;
      #1;
      chk({2'b00, irq_oe}, 8'h00);
      chk({2'b00, irq_out}, 8'h00);
   endtask : t_irq
   task automatic t_base();
      @(posedge mclk) base_switch <= 8'hFF;
      base_switch_use <= 1'b1;
      do_reset();
      H.io(10'h3FF, 8'h3C, 1'b1);
      chk(digital_output_bits, 8'h3C);
      rd(10'h302, 1'b0, 8'h00);
   endtask : t_base
   initial begin
      do_reset();
      t_dout();
      t_timer();
      t_din();
      t_irq();
      t_base();
      test_done();
   end
endmodule : pcio_port_tb_top
`default_nettype wire
